// File: verilog/pio_defines.svh
// constants for the port i/o instruction executor
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH
`define PIO_OP_PREFIX    8'hED
`define PIO_OP_IN_DEC_RP 8'hBA
`define PIO_OP_OUT_IMM   8'hD3
`define PIO_OP_OUT_STEP  8'hA3
`define PIO_OP_OUT_REG_M 8'hC7
`define PIO_OP_OUT_REG_V 8'h41
`define PIO_R_COUNT      3'h0
`define PIO_R_PORT       3'h1
`define PIO_R_D          3'h2
`define PIO_R_E          3'h3
`define PIO_R_H          3'h4
`define PIO_R_L          3'h5
`define PIO_R_RES        3'h7
`define PIO_PC_REWIND    16'h0002
`define PIO_REFRESH_N    2'h2
`define PIO_FLAG_C       0
`define PIO_FLAG_N       1
`define PIO_FLAG_PV      2
`define PIO_FLAG_H       4
`define PIO_FLAG_Z       6
`define PIO_FLAG_S       7
`define PIO_RST_WORD     16'h0000
`define PIO_RST_BYTE     8'h00
`endif

// File: verilog/pio_pkg.sv
// types for the port i/o instruction executor
package pio_pkg;
  typedef enum logic [8:0] {
    PIO_IDLE    = 9'h001,
    PIO_DECODE  = 9'h002,
    PIO_MEM_RD  = 9'h004,
    PIO_MEM_WT  = 9'h008,
    PIO_IO_CYC  = 9'h010,
    PIO_IO_WT   = 9'h020,
    PIO_MEM_WR  = 9'h040,
    PIO_REFRESH = 9'h080,
    PIO_FINISH  = 9'h100
  } pio_state_t;
  typedef enum logic [1:0] {
    PIO_K_IN_RP = 2'h0,
    PIO_K_OUT_IMM = 2'h1,
    PIO_K_OUT_REG = 2'h2,
    PIO_K_OUT_STEP = 2'h3
  } pio_kind_t;
endpackage

// File: verilog/pio_bus_if.sv
// bus request group between sequencer and bus cycle unit
`timescale 1ns/1ps
interface pio_bus_if;
  logic        req;
  logic        is_io;
  logic        wr;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport seq (output req, is_io, wr, addr, wdata, input done, rdata);
  modport cyc (input req, is_io, wr, addr, wdata, output done, rdata);
endinterface

// File: verilog/pio_bus_cycle.sv
// one memory or port bus cycle: drive, wait for ack, capture
`timescale 1ns/1ps
`include "pio_defines.svh"
module pio_bus_cycle (
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  sys_rst,
  // sequencer side
  pio_bus_if.cyc     bus,
  // external bus, ack already synchronised
  input  wire logic  ack_sync,
  input  wire logic [7:0] din,
  output logic [15:0] addr,
  output logic [7:0]  dout,
  output logic        dout_en,
  output logic        mem_rq,
  output logic        io_rq,
  output logic        rd_n,
  output logic        wr_n
);
  logic       busy, next_busy;
  logic       done_q, next_done;
  logic [7:0] rdata_q, next_rdata;
  logic [15:0] next_addr;
  logic [7:0] next_dout;
  logic next_en, next_mem, next_io, next_rd_n, next_wr_n;

  assign bus.done  = done_q;
  assign bus.rdata = rdata_q;

  always_comb begin
    next_busy  = busy;
    next_done  = 1'b0;
    next_rdata = rdata_q;
    next_addr  = addr;
    next_dout  = dout;
    next_en    = dout_en;
    next_mem   = mem_rq;
    next_io    = io_rq;
    next_rd_n  = rd_n;
    next_wr_n  = wr_n;
    // a new cycle waits for the last acknowledge to drop, else a stale ack ends it at once
    if (!busy && bus.req && !done_q && !ack_sync) begin
      next_busy = 1'b1;
      next_addr = bus.addr;
      next_dout = bus.wdata;
      next_en   = bus.wr;
      next_mem  = !bus.is_io;
      next_io   = bus.is_io;
      next_rd_n = bus.wr;
      next_wr_n = !bus.wr;
    end else if (busy && ack_sync) begin
      // capture read data on the acknowledge edge
      if (!rd_n) begin
        next_rdata = din;
      end
      next_busy = 1'b0;
      next_done = 1'b1;
      next_en   = 1'b0;
      next_mem  = 1'b0;
      next_io   = 1'b0;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy    <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= `PIO_RST_BYTE;
      addr    <= `PIO_RST_WORD;
      dout    <= `PIO_RST_BYTE;
      dout_en <= 1'b0;
      mem_rq  <= 1'b0;
      io_rq   <= 1'b0;
      rd_n    <= 1'b1;
      wr_n    <= 1'b1;
    end else begin
      busy    <= next_busy;
      done_q  <= next_done;
      rdata_q <= next_rdata;
      addr    <= next_addr;
      dout    <= next_dout;
      dout_en <= next_en;
      mem_rq  <= next_mem;
      io_rq   <= next_io;
      rd_n    <= next_rd_n;
      wr_n    <= next_wr_n;
    end
  end
endmodule

// File: verilog/pio_exec.sv
// port i/o instruction sequencer with register file and apb access
`timescale 1ns/1ps
`include "pio_defines.svh"
module pio_exec (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // processor bus pins
  output logic [15:0]      bus_addr,
  output logic [7:0]       bus_dout,
  output logic             bus_dout_en,
  input  wire logic [7:0]  bus_din,
  output logic             bus_mem_rq,
  output logic             bus_io_rq,
  output logic             bus_rd_n,
  output logic             bus_wr_n,
  output logic             bus_refresh,
  input  wire logic        bus_ack,
  // interrupt window and status
  input  wire logic        irq_pending,
  output logic             irq_accept,
  output logic             busy
);
  // ***********************************
  // register map (byte addresses)
  // ***********************************
  localparam logic [7:0] A_CTRL = 8'h00, A_OPC = 8'h04, A_PTR = 8'h08, A_CNT = 8'h0C;
  localparam logic [7:0] A_PORT = 8'h10, A_DE = 8'h14, A_RES = 8'h18, A_PC = 8'h1C;
  localparam logic [7:0] A_FLG = 8'h20, A_STAT = 8'h24;

  logic [7:0]  opc0, opc1, opc2;
  logic [15:0] ptr, pc, de;
  logic [7:0]  cnt, port, res, flags, held;
  logic        a1, a2, ack_s;
  pio_pkg::pio_state_t st, next_st;
  pio_pkg::pio_kind_t  kind, next_kind;
  logic [15:0] next_ptr, next_pc, next_de;
  logic [7:0]  next_cnt, next_port, next_res, next_flags, next_held;
  logic [1:0]  rf, next_rf;
  logic        next_irq, next_refresh, next_busy;
  logic [31:0] next_prdata;

  pio_bus_if bif ();

  pio_bus_cycle pio_bus_cycle_inst (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .bus      (bif),
    .ack_sync (ack_s),
    .din      (bus_din),
    .addr     (bus_addr),
    .dout     (bus_dout),
    .dout_en  (bus_dout_en),
    .mem_rq   (bus_mem_rq),
    .io_rq    (bus_io_rq),
    .rd_n     (bus_rd_n),
    .wr_n     (bus_wr_n)
  );

  // ***********************************
  // acknowledge synchroniser
  // ***********************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      a1 <= 1'b0;
      a2 <= 1'b0;
    end else begin
      a1 <= bus_ack;
      a2 <= a1;
    end
  end
  assign ack_s = a2;

  wire apb_wr = psel && penable && pwrite && (st == pio_pkg::PIO_IDLE);
  wire go     = apb_wr && (paddr == A_CTRL) && pwdata[0];

  // register selected by the output field
  function automatic logic [7:0] reg_sel(input logic [2:0] f);
    unique case (f)
      `PIO_R_COUNT: reg_sel = cnt;
      `PIO_R_PORT:  reg_sel = port;
      `PIO_R_D:     reg_sel = de[15:8];
      `PIO_R_E:     reg_sel = de[7:0];
      `PIO_R_H:     reg_sel = ptr[15:8];
      `PIO_R_L:     reg_sel = ptr[7:0];
      `PIO_R_RES:   reg_sel = res;
      default:      reg_sel = `PIO_RST_BYTE; // flag code is not an output form
    endcase
  endfunction

  // ***********************************
  // sequencer
  // ***********************************
  always_comb begin
    next_st      = st;
    next_kind    = kind;
    next_ptr     = ptr;
    next_pc      = pc;
    next_de      = de;
    next_cnt     = cnt;
    next_port    = port;
    next_res     = res;
    next_flags   = flags;
    next_held    = held;
    next_rf      = rf;
    next_irq     = 1'b0;
    next_refresh = 1'b0;
    bif.req      = 1'b0;
    bif.is_io    = 1'b0;
    bif.wr       = 1'b0;
    bif.addr     = `PIO_RST_WORD;
    bif.wdata    = `PIO_RST_BYTE;
    if (apb_wr) begin
      unique case (paddr)
        A_PTR:  next_ptr  = pwdata[15:0];
        A_CNT:  next_cnt  = pwdata[7:0];
        A_PORT: next_port = pwdata[7:0];
        A_DE:   next_de   = pwdata[15:0];
        A_RES:  next_res  = pwdata[7:0];
        A_PC:   next_pc   = pwdata[15:0];
        A_FLG:  next_flags = pwdata[7:0];
        default: ;
      endcase
    end
    unique case (st)
      pio_pkg::PIO_IDLE: if (go) next_st = pio_pkg::PIO_DECODE;
      pio_pkg::PIO_DECODE: begin
        next_st = pio_pkg::PIO_IO_CYC;
        if (opc0 == `PIO_OP_OUT_IMM) begin
          next_kind = pio_pkg::PIO_K_OUT_IMM;
        end else if (opc0 == `PIO_OP_PREFIX && opc1 == `PIO_OP_IN_DEC_RP) begin
          next_kind = pio_pkg::PIO_K_IN_RP;
        end else if (opc0 == `PIO_OP_PREFIX && opc1 == `PIO_OP_OUT_STEP) begin
          next_kind = pio_pkg::PIO_K_OUT_STEP;
          next_st   = pio_pkg::PIO_MEM_RD;
        end else if (opc0 == `PIO_OP_PREFIX &&
                     (opc1 & `PIO_OP_OUT_REG_M) == `PIO_OP_OUT_REG_V &&
                     opc1[5:3] != 3'h6) begin
          next_kind = pio_pkg::PIO_K_OUT_REG;
        end else begin
          next_st = pio_pkg::PIO_IDLE; // unsupported opcode ignored
        end
      end
      pio_pkg::PIO_MEM_RD: begin
        bif.req = 1'b1; bif.addr = ptr;
        next_st = pio_pkg::PIO_MEM_WT;
      end
      pio_pkg::PIO_MEM_WT: begin
        bif.req = 1'b1; bif.addr = ptr;
        if (bif.done) begin
          next_held = bif.rdata;
          next_cnt  = cnt - 8'h01;
          next_st   = pio_pkg::PIO_IO_CYC;
        end
      end
      pio_pkg::PIO_IO_CYC, pio_pkg::PIO_IO_WT: begin
        bif.req = 1'b1; bif.is_io = 1'b1;
        unique case (kind)
          pio_pkg::PIO_K_IN_RP:   bif.addr = {cnt, port};
          pio_pkg::PIO_K_OUT_IMM: begin
            bif.wr = 1'b1; bif.addr = {res, opc1}; bif.wdata = res;
          end
          pio_pkg::PIO_K_OUT_REG: begin
            bif.wr = 1'b1; bif.addr = {cnt, port}; bif.wdata = reg_sel(opc1[5:3]);
          end
          pio_pkg::PIO_K_OUT_STEP: begin
            bif.wr = 1'b1; bif.addr = {cnt, port}; bif.wdata = held;
          end
        endcase
        next_st = pio_pkg::PIO_IO_WT;
        if (st == pio_pkg::PIO_IO_WT && bif.done) begin
          next_held = bif.rdata;
          unique case (kind)
            pio_pkg::PIO_K_IN_RP:    next_st = pio_pkg::PIO_MEM_WR;
            pio_pkg::PIO_K_OUT_STEP: begin
              next_ptr = ptr + 16'h0001;
              next_flags[`PIO_FLAG_Z] = (cnt == `PIO_RST_BYTE);
              next_flags[`PIO_FLAG_N] = 1'b1;
              next_st = pio_pkg::PIO_FINISH;
            end
            default: next_st = pio_pkg::PIO_FINISH;
          endcase
        end
      end
      pio_pkg::PIO_MEM_WR: begin
        bif.req = 1'b1; bif.wr = 1'b1; bif.addr = ptr; bif.wdata = held;
        if (bif.done) begin
          next_ptr = ptr - 16'h0001;
          next_cnt = cnt - 8'h01;
          next_rf  = `PIO_REFRESH_N;
          next_st  = pio_pkg::PIO_REFRESH;
        end
      end
      pio_pkg::PIO_REFRESH: begin
        // refresh cycles run before the repeat decision
        next_refresh = 1'b1;
        next_rf = rf - 2'h1;
        if (rf == 2'h1) begin
          next_irq = irq_pending;
          if (cnt == `PIO_RST_BYTE) begin
            next_flags[`PIO_FLAG_Z] = 1'b1;
            next_flags[`PIO_FLAG_N] = 1'b1;
            next_st = pio_pkg::PIO_FINISH;
          end else begin
            next_pc = pc - `PIO_PC_REWIND;
            // an accepted interrupt stops here; pc already points at the prefix
            next_st = irq_pending ? pio_pkg::PIO_FINISH : pio_pkg::PIO_IO_CYC;
          end
        end
      end
      pio_pkg::PIO_FINISH: next_st = pio_pkg::PIO_IDLE;
    endcase
  end

  // ***********************************
  // apb read path, zero wait states
  // ***********************************
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      A_OPC:  next_prdata = {8'h00, opc2, opc1, opc0};
      A_PTR:  next_prdata = {16'h0000, ptr};
      A_CNT:  next_prdata = {24'h000000, cnt};
      A_PORT: next_prdata = {24'h000000, port};
      A_DE:   next_prdata = {16'h0000, de};
      A_RES:  next_prdata = {24'h000000, res};
      A_PC:   next_prdata = {16'h0000, pc};
      A_FLG:  next_prdata = {24'h000000, flags};
      A_STAT: next_prdata = {31'h00000000, st != pio_pkg::PIO_IDLE};
      default: ;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st          <= pio_pkg::PIO_IDLE;
      kind        <= pio_pkg::PIO_K_IN_RP;
      ptr         <= `PIO_RST_WORD;
      pc          <= `PIO_RST_WORD;
      de          <= `PIO_RST_WORD;
      cnt         <= `PIO_RST_BYTE;
      port        <= `PIO_RST_BYTE;
      res         <= `PIO_RST_BYTE;
      flags       <= `PIO_RST_BYTE;
      held        <= `PIO_RST_BYTE;
      rf          <= 2'h0;
      opc0        <= `PIO_RST_BYTE;
      opc1        <= `PIO_RST_BYTE;
      opc2        <= `PIO_RST_BYTE;
      irq_accept  <= 1'b0;
      bus_refresh <= 1'b0;
      busy        <= 1'b0;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      st    <= next_st;
      kind  <= next_kind;
      ptr   <= next_ptr;
      pc    <= next_pc;
      de    <= next_de;
      cnt   <= next_cnt;
      port  <= next_port;
      res   <= next_res;
      flags <= next_flags;
      held  <= next_held;
      rf    <= next_rf;
      if (apb_wr && paddr == A_OPC) begin
        opc0 <= pwdata[7:0];
        opc1 <= pwdata[15:8];
        opc2 <= pwdata[23:16];
      end
      irq_accept  <= next_irq;
      bus_refresh <= next_refresh;
      busy        <= (next_st != pio_pkg::PIO_IDLE);
      prdata      <= next_prdata;
      pready      <= psel && !penable;
      pslverr     <= psel && !penable && (paddr > A_STAT || paddr[1:0] != 2'h0);
    end
  end
endmodule

// File: bench/pio_periph.sv
// far-side model: memory and port devices on the processor bus
`timescale 1ns/1ps
module pio_periph (
  // clock
  input  wire logic        core_clk,
  // processor bus
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_dout,
  input  wire logic        bus_mem_rq,
  input  wire logic        bus_io_rq,
  input  wire logic        bus_rd_n,
  input  wire logic        bus_wr_n,
  output logic [7:0]       bus_din,
  output logic             bus_ack,
  // answer delay
  input  wire logic [2:0]  lag
);
  logic [7:0] mem [0:65535];
  logic [7:0] port_q [$];
  logic [7:0] last;
  logic [7:0] out_byte;
  int         wait_n;
  initial begin
    bus_ack = 1'b0;
    bus_din = 8'h00;
    last = 8'h00;
    wait_n = 0;
  end
  always @(posedge core_clk) begin
    if (bus_rd_n && bus_wr_n) begin
      // released line must not keep the old byte
      bus_ack <= 1'b0;
      wait_n <= 0;
      bus_din <= ~last;
    end else if (!bus_ack) begin
      if (wait_n < lag) begin
        wait_n <= wait_n + 1;
      end else begin
        bus_ack <= 1'b1;
        if (!bus_rd_n) begin
          last = bus_io_rq ? port_q.pop_front() : mem[bus_addr];
          bus_din <= last;
        end
        if (!bus_wr_n && bus_mem_rq) mem[bus_addr] <= bus_dout;
        if (!bus_wr_n && bus_io_rq) out_byte <= bus_dout;
      end
    end
  end
endmodule

// File: bench/pio_exec_monitor.sv
// checker for the port i/o executor pins
`timescale 1ns/1ps
module pio_exec_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // processor bus
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_dout,
  input wire logic        bus_dout_en,
  input wire logic [7:0]  bus_din,
  input wire logic        bus_mem_rq,
  input wire logic        bus_io_rq,
  input wire logic        bus_rd_n,
  input wire logic        bus_wr_n,
  input wire logic        bus_refresh,
  input wire logic        bus_ack,
  // interrupt window
  input wire logic        irq_pending,
  input wire logic        irq_accept
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] in_byte;
  logic [7:0] next_in_byte;
  // last port byte, followed into memory
  always_comb begin
    next_in_byte = in_byte;
    if (bus_io_rq && !bus_rd_n && bus_ack) next_in_byte = bus_din;
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_byte <= 8'h00;
    end else begin
      in_byte <= next_in_byte;
    end
  end
  AST_STROBE_EXCL: assert property (!(!bus_rd_n && !bus_wr_n))
    else $error("read and write strobes low together");
  AST_RQ_EXCL: assert property (!(bus_mem_rq && bus_io_rq))
    else $error("memory and port cycle together");
  AST_DOUT_EN: assert property (!bus_wr_n |-> bus_dout_en)
    else $error("write strobe without data drive");
  AST_HOLD: assert property (!bus_wr_n && $past(!bus_wr_n) |-> $stable(bus_addr) && $stable(bus_dout))
    else $error("write cycle changed address or data");
  AST_RELEASE: assert property ($rose(bus_ack) |-> ##[1:6] (bus_rd_n && bus_wr_n))
    else $error("strobes held after acknowledge");
  AST_PREADY_ONE: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready stayed high");
  AST_REFRESH: assert property ($rose(bus_mem_rq && !bus_wr_n) |-> ##[1:40] bus_refresh)
    else $error("no refresh after transfer");
  AST_IN_TO_MEM: assert property ($rose(bus_mem_rq && !bus_wr_n) |-> bus_dout == in_byte)
    else $error("stored byte differs from port byte");
  AST_ACCEPT: assert property (irq_accept |-> irq_pending || $past(irq_pending))
    else $error("accept without pending interrupt");
  cover property (irq_accept);
  cover property ($rose(bus_io_rq && !bus_rd_n));
  cover property ($rose(bus_io_rq && !bus_wr_n));
endmodule
bind pio_exec pio_exec_monitor pio_exec_monitor_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
  .bus_addr(bus_addr), .bus_dout(bus_dout), .bus_dout_en(bus_dout_en), .bus_din(bus_din),
  .bus_mem_rq(bus_mem_rq), .bus_io_rq(bus_io_rq), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
  .bus_refresh(bus_refresh), .bus_ack(bus_ack), .irq_pending(irq_pending),
  .irq_accept(irq_accept)
);

// File: bench/port_io_instruction_exec_bench.sv
// self-checking bench for the port i/o instruction executor
`timescale 1ns/1ps
`include "pio_defines.svh"
module port_io_instruction_exec_bench;
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, bus_dout, bus_din;
  logic [31:0] pwdata, prdata;
  logic [15:0] bus_addr;
  logic        bus_dout_en, bus_mem_rq, bus_io_rq, bus_rd_n, bus_wr_n, bus_refresh, bus_ack;
  logic        irq_pending, irq_accept, busy, ack_q;
  logic [2:0]  lag;
  logic [31:0] exp_q [$];
  int          err_total, checks_done, ref_n, acc_n;
  pio_exec pio_exec_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_addr(bus_addr), .bus_dout(bus_dout), .bus_dout_en(bus_dout_en), .bus_din(bus_din),
    .bus_mem_rq(bus_mem_rq), .bus_io_rq(bus_io_rq), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
    .bus_refresh(bus_refresh), .bus_ack(bus_ack), .irq_pending(irq_pending),
    .irq_accept(irq_accept), .busy(busy));
  pio_periph pio_periph_inst (
    .core_clk(core_clk), .bus_addr(bus_addr), .bus_dout(bus_dout), .bus_mem_rq(bus_mem_rq),
    .bus_io_rq(bus_io_rq), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_din(bus_din),
    .bus_ack(bus_ack), .lag(lag));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // port cycles and apb reads share one queue; they never overlap in time
  always @(posedge core_clk) begin
    ack_q <= bus_ack;
    if (bus_io_rq && bus_ack && !ack_q)
      chk({7'h0, ~bus_wr_n, bus_addr, bus_wr_n ? 8'h00 : bus_dout}, exp_q.pop_front());
    if (psel && penable && pready && !pwrite) chk(prdata, exp_q.pop_front());
    if (bus_refresh === 1'b1) ref_n++;
    if (irq_accept === 1'b1) acc_n++;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      test_done();
    end
    chk(pslverr, er);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle, so no strobe is driven twice in one step
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0, er);
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic run(input logic [15:0] op);
    wr(8'h04, {16'h0, op});
    lag <= 3'($urandom);
    wr(8'h00, 32'h1);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask
  task automatic blk(input logic [7:0] c, input int n, input logic irq);
    logic [15:0] hl;
    logic [7:0]  d [$];
    int          k;
    int          r0, a0;
    hl = 16'($urandom);
    wr(8'h08, {16'h0, hl});
    wr(8'h0C, {24'h0, c});
    wr(8'h10, 32'h07);
    wr(8'h20, 32'h01);
    wr(8'h1C, 32'h0100);
    r0 = ref_n;
    a0 = acc_n;
    irq_pending <= irq;
    for (k = 0; k < n; k++) begin
      d.push_back(8'($urandom));
      pio_periph_inst.port_q.push_back(d[k]);
      exp_q.push_back({8'h0, 8'(c - k), 8'h07, 8'h00});
    end
    run({`PIO_OP_IN_DEC_RP, `PIO_OP_PREFIX});
    irq_pending <= 1'b0;
    for (k = 0; k < n; k++) chk(pio_periph_inst.mem[16'(hl - k)], d[k]);
    chk(ref_n - r0, 2 * n);
    chk(acc_n - a0, irq);
    rd(8'h08, 16'(hl - n), 1'b0);
    rd(8'h0C, 8'(c - n), 1'b0);
    if (irq) rd(8'h1C, 32'hFE, 1'b0);
    else rd(8'h20, 32'h43, 1'b0);
  endtask
  initial begin
    logic [7:0]  v, p, c, r;
    logic [7:0]  tbl [8];
    logic [15:0] w, hl;
    int          i;
    {psel, penable, pwrite, irq_pending, sys_rst} = 5'h01;
    {paddr, pwdata, lag} = 43'h0;
    void'($urandom(32'h1f92));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (i = 0; i < 10; i++) rd(8'(i * 4), 32'h0, 1'b0);
    rd(8'h28, 32'h0, 1'b1);
    // immediate-port output, flags preset to a mixed pattern
    r = 8'($urandom);
    p = 8'($urandom);
    wr(8'h20, 32'hD5);
    wr(8'h18, {24'h0, r});
    exp_q.push_back({7'h0, 1'b1, r, p, r});
    run({p, `PIO_OP_OUT_IMM});
    chk(pio_periph_inst.out_byte, r);
    rd(8'h20, 32'hD5, 1'b0);
    // register-selected output over every field code except 6
    c = 8'($urandom);
    p = 8'($urandom);
    w = 16'($urandom);
    hl = 16'($urandom);
    wr(8'h0C, {24'h0, c});
    wr(8'h10, {24'h0, p});
    wr(8'h14, {16'h0, w});
    wr(8'h08, {16'h0, hl});
    tbl = '{c, p, w[15:8], w[7:0], hl[15:8], hl[7:0], 8'h00, r};
    for (i = 0; i < 8; i++) begin
      if (i != 6) begin
        exp_q.push_back({7'h0, 1'b1, c, p, tbl[i]});
        run({8'h41 | 8'(i << 3), `PIO_OP_PREFIX});
      end
    end
    rd(8'h20, 32'hD5, 1'b0);
    // output step: count ending at zero, then not
    for (i = 0; i < 2; i++) begin
      c = (i == 0) ? 8'h01 : 8'($urandom_range(2, 255));
      v = 8'($urandom);
      pio_periph_inst.mem[hl] = v;
      wr(8'h0C, {24'h0, c});
      wr(8'h20, 32'h01);
      exp_q.push_back({7'h0, 1'b1, c - 8'h01, p, v});
      run({`PIO_OP_OUT_STEP, `PIO_OP_PREFIX});
      rd(8'h08, 16'(hl + 16'h1), 1'b0);
      rd(8'h0C, c - 8'h01, 1'b0);
      rd(8'h20, (i == 0) ? 32'h43 : 32'h03, 1'b0);
      hl = 16'(hl + 16'h1);
    end
    blk(8'h03, 3, 1'b0);
    blk(8'h00, 256, 1'b0);
    blk(8'h05, 1, 1'b1);
    chk(exp_q.size(), 0);
    test_done();
  end
endmodule
